// ### core/dsl_pkg.sv
// Constants and types for the serial load and power-down front end of a 14-bit converter.
// Assumes a 125 MHz reference clock and a write-only three-wire host link.
// Operation
// (RQ1) Frame begins when the host drives frame sync low; shifting is enabled.
// (RQ2) Serial data is sampled on each falling serial clock edge into 16 bits.
// (RQ3) Host keeps the serial clock at or below 30 MHz; the bench host model clocks at a 32 ns period, 31.25 MHz.
// (RQ4) The 16th falling edge takes the last bit and executes the command at once.
// (RQ5) Host holds frame sync high at least 33 ns before the next frame.
// (RQ6) The first two bits of a frame form the operating mode field.
// (RQ7) The remaining 14 bits go to the data register on the 16th edge.
// (RQ8) Frame sync rising early clears the shifter; data and mode stay unchanged.
// (RQ9) Power-up loads zero code, 0 V, kept until the first complete frame.
// (RQ10) Mode decode, upper bit first: normal, 1k, 100k, three-state.
// (RQ11) Power-down parts output from amplifier; ground via resistor or leave open.
// (RQ12) Power-down stops bias, amplifier and string; data register is kept.
// (RQ13) Leaving power-down takes 13 us at 5 V or 16 us at 3 V.
// (RQ14) Data register code selects exactly one resistor string tap.
// (RQ15) Host may idle frame sync low between frames, raising it before the next.
// (RQ16) Host sends each frame most significant bit first.
// (RQ17) Byte-wide hosts keep frame sync low across two bytes, then raise it.
// (RQ18) After executing, further clock edges are ignored until frame sync toggles.

package dsl_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CODE_W = 14;
  localparam int MODE_W = 2;
  localparam int CNT_W = 5;
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;

  localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
  localparam logic [MODE_W-1:0] MODE_PD_1K = 2'h1;
  localparam logic [MODE_W-1:0] MODE_PD_100K = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PD_HIZ = 2'h3;

  localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h10;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int WAKE_5V_NS = 13;
  localparam int WAKE_3V_NS = 16;
  localparam int WAKE_5V_CYC = (WAKE_5V_NS * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_3V_CYC = (WAKE_3V_NS * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_W = 12;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [CODE_W-1:0] code;
  } dsl_word_t;

  typedef struct packed {
    logic bias_en;
    logic amp_en;
    logic string_en;
    logic amp_to_pin;
    logic pd_1k_en;
    logic pd_100k_en;
  } dsl_analog_t;

endpackage : dsl_pkg

// ### core/dsl_top.sv
// Serial load front end: link-side shifter on the serial clock, register side on ref_clk.
// Assumes the host stops the serial clock outside frames and keeps the link timing.
`timescale 1ns/1ps

module dsl_top #(
  parameter int CODE_BITS = dsl_pkg::CODE_W,
  parameter int WAKE_FAST_CYC = dsl_pkg::WAKE_5V_CYC,
  parameter int WAKE_SLOW_CYC = dsl_pkg::WAKE_3V_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic link_sclk,
  input wire logic frame_sync_b,
  input wire logic serial_data_in,
  input wire logic supply_low,
  output logic [CODE_BITS-1:0] dac_code,
  output logic [dsl_pkg::MODE_W-1:0] op_mode,
  output logic mode_bit_upper,
  output logic mode_bit_lower,
  output dsl_pkg::dsl_analog_t analog_ctl,
  output logic [CODE_BITS-1:0] tap_index,
  output logic tap_close,
  output logic output_valid,
  output logic load_pulse,
  output logic abort_pulse
);

  if (CODE_BITS != dsl_pkg::CODE_W) begin : g_bad_width
    $error("dsl_top: code width must match the frame layout");
  end
  if (WAKE_FAST_CYC < 1 || WAKE_SLOW_CYC < 1 || WAKE_SLOW_CYC >= (1 << dsl_pkg::WAKE_W) ||
      WAKE_FAST_CYC >= (1 << dsl_pkg::WAKE_W)) begin : g_bad_wake
    $error("dsl_top: wake counts out of range");
  end

  // Frame layout is fixed by the link: mode leads, code follows
  if (dsl_pkg::CODE_W + dsl_pkg::MODE_W != dsl_pkg::FRAME_BITS) begin : g_bad_frame
    $error("dsl_top: mode and code fields must fill the frame");
  end
  if ((1 << dsl_pkg::CNT_W) <= dsl_pkg::FRAME_BITS) begin : g_bad_cnt
    $error("dsl_top: bit counter too narrow for the frame");
  end
  if (dsl_pkg::MODE_MSB != dsl_pkg::FRAME_BITS - 1 ||
      dsl_pkg::MODE_LSB != dsl_pkg::CODE_W) begin : g_bad_mode
    $error("dsl_top: mode field must lead the frame");
  end

  localparam logic [dsl_pkg::WAKE_W-1:0] WAKE_FAST = dsl_pkg::WAKE_W'(WAKE_FAST_CYC - 1);
  localparam logic [dsl_pkg::WAKE_W-1:0] WAKE_SLOW = dsl_pkg::WAKE_W'(WAKE_SLOW_CYC - 1);

  // Link domain, falling edge of the serial clock
  logic [dsl_pkg::CNT_W-1:0] bit_cnt;
  logic [dsl_pkg::FRAME_BITS-1:0] shifter;
  logic [dsl_pkg::FRAME_BITS-1:0] next_shifter;
  dsl_pkg::dsl_word_t word_link;
  logic done_tgl;
  logic frame_full;
  logic last_edge;

  assign frame_full = (bit_cnt == dsl_pkg::CNT_LAST);
  assign last_edge = (bit_cnt == dsl_pkg::CNT_LAST - 5'h01);
  assign next_shifter = {shifter[dsl_pkg::FRAME_BITS-2:0], serial_data_in};

  // Frame sync high holds the counter cleared; its fall opens the frame
  always_ff @(negedge link_sclk or posedge frame_sync_b) begin
    if (frame_sync_b) begin
      bit_cnt <= '0; // RQ8
    end else if (!frame_full) begin // RQ18
      bit_cnt <= bit_cnt + 5'h01; // RQ1
    end
  end

  // Early rise of frame sync throws the partial word away
  always_ff @(negedge link_sclk or posedge frame_sync_b) begin
    if (frame_sync_b) begin
      shifter <= '0; // RQ8
    end else if (!frame_full) begin // RQ18
      shifter <= next_shifter; // RQ2
    end
  end

  // Word is held until the next complete frame, long after the crossing settles
  always_ff @(negedge link_sclk or negedge rst_b) begin
    if (!rst_b) begin
      word_link <= '0;
    end else if (!frame_sync_b && last_edge) begin // RQ4
      word_link.mode <= next_shifter[dsl_pkg::MODE_MSB:dsl_pkg::MODE_LSB]; // RQ6
      word_link.code <= next_shifter[CODE_BITS-1:0]; // RQ7
    end
  end

  // A toggle, not a pulse: the serial clock may stop right after the last edge
  always_ff @(negedge link_sclk or negedge rst_b) begin
    if (!rst_b) begin
      done_tgl <= 1'b0;
    end else if (!frame_sync_b && last_edge) begin
      done_tgl <= ~done_tgl; // RQ4
    end
  end

  // Crossings into ref_clk
  logic done_meta;
  logic done_sync;
  logic done_prev;
  logic sync_meta;
  logic sync_sync;
  logic sync_prev;
  logic low_meta;
  logic low_sync;
  logic frame_event;
  logic sync_rise;
  logic sync_fall;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else if (clk_en) begin
      done_meta <= done_tgl;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync_meta <= 1'b1;
      sync_sync <= 1'b1;
      sync_prev <= 1'b1;
    end else if (clk_en) begin
      sync_meta <= frame_sync_b;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end

  // Supply level only picks the wake count, so a slow crossing is harmless
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      low_meta <= 1'b0;
      low_sync <= 1'b0;
    end else if (clk_en) begin
      low_meta <= supply_low;
      low_sync <= low_meta;
    end
  end

  assign frame_event = done_sync ^ done_prev;
  assign sync_rise = sync_sync && !sync_prev;
  assign sync_fall = !sync_sync && sync_prev;

  // Frame bookkeeping: a rise with no executed frame since the fall is an abort
  logic frame_open;
  logic frame_done;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frame_open <= 1'b0;
    end else if (clk_en) begin
      if (sync_fall) begin
        frame_open <= 1'b1;
      end else if (sync_rise) begin
        frame_open <= 1'b0;
      end
    end
  end

  // Completion seen in the same cycle as the next fall still counts
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frame_done <= 1'b0;
    end else if (clk_en) begin
      if (frame_event) begin
        frame_done <= 1'b1;
      end else if (sync_fall) begin
        frame_done <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      abort_pulse <= 1'b0;
    end else if (clk_en) begin
      abort_pulse <= sync_rise && frame_open && !frame_done && !frame_event; // RQ8
    end
  end

  // Data register and operating mode
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dac_code <= dsl_pkg::CODE_RESET; // RQ9
    end else if (clk_en && frame_event) begin
      // Code is loaded in power-down too; it takes effect on wake
      dac_code <= word_link.code; // RQ7
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      op_mode <= dsl_pkg::MODE_NORMAL; // RQ9
    end else if (clk_en && frame_event) begin
      op_mode <= word_link.mode; // RQ10
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_bit_upper <= 1'b0;
      mode_bit_lower <= 1'b0;
    end else if (clk_en && frame_event) begin
      mode_bit_upper <= word_link.mode[1]; // RQ10
      mode_bit_lower <= word_link.mode[0]; // RQ10
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      load_pulse <= 1'b0;
    end else if (clk_en) begin
      load_pulse <= frame_event; // RQ4
    end
  end

  // Power state and wake timer
  typedef enum logic [1:0] {
    DSL_ACTIVE,
    DSL_DOWN,
    DSL_WAKING
  } dsl_pwr_t;

  dsl_pwr_t pwr_state;
  dsl_pwr_t next_pwr_state;
  logic [dsl_pkg::WAKE_W-1:0] wake_cnt;
  logic [dsl_pkg::WAKE_W-1:0] next_wake_cnt;
  logic [dsl_pkg::MODE_W-1:0] mode_now;

  // Decision uses the mode being loaded this cycle so outputs track in one step
  assign mode_now = frame_event ? word_link.mode : op_mode;

  always_comb begin
    next_pwr_state = pwr_state;
    next_wake_cnt = wake_cnt;
    unique case (pwr_state)
      DSL_ACTIVE: begin
        if (mode_now != dsl_pkg::MODE_NORMAL) begin
          next_pwr_state = DSL_DOWN; // RQ12
        end
      end
      DSL_DOWN: begin
        if (mode_now == dsl_pkg::MODE_NORMAL) begin
          next_pwr_state = DSL_WAKING; // RQ13
          next_wake_cnt = low_sync ? WAKE_SLOW : WAKE_FAST; // RQ13
        end
      end
      DSL_WAKING: begin
        if (mode_now != dsl_pkg::MODE_NORMAL) begin
          next_pwr_state = DSL_DOWN;
        end else if (wake_cnt == '0) begin
          next_pwr_state = DSL_ACTIVE; // RQ13
        end else begin
          next_wake_cnt = wake_cnt - 12'h001;
        end
      end
      default: begin
        next_pwr_state = DSL_DOWN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pwr_state <= DSL_ACTIVE;
    end else if (clk_en) begin
      pwr_state <= next_pwr_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wake_cnt <= '0;
    end else if (clk_en) begin
      wake_cnt <= next_wake_cnt;
    end
  end

  // Analog controls
  dsl_pkg::dsl_analog_t next_analog;
  logic next_powered;

  always_comb begin
    next_powered = (next_pwr_state != DSL_DOWN);
    next_analog = '0;
    next_analog.bias_en = next_powered; // RQ12
    next_analog.amp_en = next_powered; // RQ12
    next_analog.string_en = next_powered; // RQ12
    next_analog.amp_to_pin = next_powered; // RQ11
    next_analog.pd_1k_en = !next_powered && (mode_now == dsl_pkg::MODE_PD_1K); // RQ11
    next_analog.pd_100k_en = !next_powered && (mode_now == dsl_pkg::MODE_PD_100K); // RQ11
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      analog_ctl <= '0;
      analog_ctl.bias_en <= 1'b1;
      analog_ctl.amp_en <= 1'b1;
      analog_ctl.string_en <= 1'b1;
      analog_ctl.amp_to_pin <= 1'b1;
    end else if (clk_en) begin
      analog_ctl <= next_analog;
    end
  end

  // One tap closes, from the code that is stored; open while the string is off
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tap_index <= dsl_pkg::CODE_RESET; // RQ9
    end else if (clk_en) begin
      tap_index <= frame_event ? word_link.code : dac_code; // RQ14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tap_close <= 1'b1;
    end else if (clk_en) begin
      tap_close <= next_powered; // RQ14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      output_valid <= 1'b1;
    end else if (clk_en) begin
      output_valid <= (next_pwr_state == DSL_ACTIVE); // RQ13
    end
  end

endmodule : dsl_top

// ### dv/dsl_top_props.sv
// Port checker for dsl_top.
// Assumes wake counts that fit the bench's short parameters.
`timescale 1ns/1ps
module dsl_top_props #(
  parameter int CODE_BITS = 14,
  parameter int WAKE_SLOW_CYC = 6
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [CODE_BITS-1:0] dac_code,
  input wire logic [dsl_pkg::MODE_W-1:0] op_mode,
  input wire logic mode_bit_upper,
  input wire logic mode_bit_lower,
  input wire dsl_pkg::dsl_analog_t analog_ctl,
  input wire logic [CODE_BITS-1:0] tap_index,
  input wire logic tap_close,
  input wire logic output_valid,
  input wire logic load_pulse,
  input wire logic abort_pulse
);
  localparam int WAKE_MAX = WAKE_SLOW_CYC + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wake_go;
    load_pulse && op_mode == 2'h0 && $past(op_mode) != 2'h0;
  endsequence
  sequence s_wake_wait;
    !output_valid [*3] ##[1:WAKE_MAX] output_valid;
  endsequence
  property p_tap; tap_index == dac_code; endproperty
  property p_bits; {mode_bit_upper, mode_bit_lower} == op_mode; endproperty
  property p_down;
    op_mode != 2'h0 |-> !tap_close && !output_valid &&
      analog_ctl == {4'h0, op_mode == 2'h1, op_mode == 2'h2};
  endproperty
  property p_up; op_mode == 2'h0 |-> analog_ctl == 6'h3c && tap_close; endproperty
  property p_pulse; load_pulse |=> !load_pulse; endproperty
  property p_abort; abort_pulse |-> !load_pulse && $stable(dac_code) && $stable(op_mode); endproperty
  property p_load; !$stable(dac_code) || !$stable(op_mode) |-> load_pulse; endproperty
  property p_wake; s_wake_go |-> s_wake_wait; endproperty
  a_tap: assert property (p_tap) else $error("tap differs from code");
  a_bits: assert property (p_bits) else $error("mode bits differ");
  a_down: assert property (p_down) else $error("bad power-down pattern");
  a_up: assert property (p_up) else $error("bad powered pattern");
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
  a_abort: assert property (p_abort) else $error("abort changed state");
  a_load: assert property (p_load) else $error("update without load");
  a_wake: assert property (p_wake) else $error("wake time wrong");
endmodule : dsl_top_props

bind dsl_top dsl_top_props #(.CODE_BITS(CODE_BITS), .WAKE_SLOW_CYC(WAKE_SLOW_CYC)) u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .dac_code(dac_code), .op_mode(op_mode),
  .mode_bit_upper(mode_bit_upper), .mode_bit_lower(mode_bit_lower),
  .analog_ctl(analog_ctl), .tap_index(tap_index), .tap_close(tap_close),
  .output_valid(output_valid), .load_pulse(load_pulse), .abort_pulse(abort_pulse)
);

// ### dv/dsl_host_model.sv
// Host serial master for the three-wire link.
// Clock idles high and stands still outside frames.
`timescale 1ns/1ps
module dsl_host_model (
  output logic link_sclk,
  output logic frame_sync_b,
  output logic serial_data_in
);
  initial begin
    link_sclk = 1'b1;
    frame_sync_b = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic shift_bits(input logic [15:0] word, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_in = word[i];
      #16 link_sclk = 1'b0;
      #16 link_sclk = 1'b1;
    end
    // Inverse so a stale bit never looks valid
    serial_data_in = ~serial_data_in;
  endtask : shift_bits
  task automatic start();
    frame_sync_b = 1'b1;
    #40 frame_sync_b = 1'b0;
    #20;
  endtask : start
  task automatic frame(input logic [15:0] word, input int n);
    start();
    shift_bits(word, n);
    // Complete frames idle sync low to save power
    if (n < 16) frame_sync_b = 1'b1;
  endtask : frame
  task automatic frame_bytes(input logic [15:0] word);
    start();
    shift_bits(word, 8);
    #100;
    shift_bits({word[7:0], 8'h00}, 8);
    frame_sync_b = 1'b1;
  endtask : frame_bytes
endmodule : dsl_host_model

// ### dv/dsl_top_tb.sv
// Self-checking bench for dsl_top driven by the host link model.
// Assumes short wake counts of 4 and 6 cycles.
`timescale 1ns/1ps
module dsl_top_tb;
  localparam int FAST = 4;
  localparam int SLOW = 6;
  logic ref_clk;
  logic rst_b;
  logic clk_en;
  logic supply_low;
  logic link_sclk;
  logic frame_sync_b;
  logic serial_data_in;
  logic [dsl_pkg::CODE_W-1:0] dac_code;
  logic [dsl_pkg::CODE_W-1:0] tap_index;
  logic [dsl_pkg::MODE_W-1:0] op_mode;
  logic mode_bit_upper;
  logic mode_bit_lower;
  dsl_pkg::dsl_analog_t analog_ctl;
  logic tap_close;
  logic output_valid;
  logic load_pulse;
  logic abort_pulse;
  logic got_load;
  logic got_abort;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  dsl_top #(.WAKE_FAST_CYC(FAST), .WAKE_SLOW_CYC(SLOW)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .link_sclk(link_sclk),
    .frame_sync_b(frame_sync_b), .serial_data_in(serial_data_in), .supply_low(supply_low),
    .dac_code(dac_code), .op_mode(op_mode), .mode_bit_upper(mode_bit_upper),
    .mode_bit_lower(mode_bit_lower), .analog_ctl(analog_ctl), .tap_index(tap_index),
    .tap_close(tap_close), .output_valid(output_valid), .load_pulse(load_pulse),
    .abort_pulse(abort_pulse)
  );
  dsl_host_model u_host (
    .link_sclk(link_sclk), .frame_sync_b(frame_sync_b), .serial_data_in(serial_data_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Stops at the first pulse so wake timing can be counted after it
  task automatic wait_ev();
    got_load = 1'b0;
    got_abort = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      #1;
      got_load = load_pulse;
      got_abort = abort_pulse;
      if (got_load === 1'b1 || got_abort === 1'b1) break;
    end
  endtask : wait_ev

  task automatic check_state(input logic [1:0] m, input logic [13:0] c);
    check({14'h0, op_mode}, {14'h0, m});
    check({14'h0, mode_bit_upper, mode_bit_lower}, {14'h0, m});
    check({2'h0, dac_code}, {2'h0, c});
    check({2'h0, tap_index}, {2'h0, c});
    check({10'h0, analog_ctl}, {10'h0, m == 2'h0 ? 6'h3c : {4'h0, m == 2'h1, m == 2'h2}});
    check({15'h0, tap_close}, {15'h0, m == 2'h0});
  endtask : check_state

  task automatic load(input logic [15:0] w);
    u_host.frame(w, 16);
    wait_ev();
    check({15'h0, got_load}, 16'h0001);
    check_state(w[15:14], w[13:0]);
  endtask : load

  task automatic t_modes();
    // Codes 3ffd..3fff then wrap to zero on the return to normal
    for (int m = 1; m < 5; m++) begin
      load({m[1:0], 14'h3ffc + 14'(m)});
      check({15'h0, output_valid}, 16'h0000);
    end
  endtask : t_modes

  task automatic t_wake(input logic slow, input int exp);
    int n;
    @(posedge ref_clk);
    supply_low <= slow;
    load(16'h8123);
    load(16'h0123);
    n = 0;
    while (output_valid !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(16'(n), 16'(exp));
  endtask : t_wake

  task automatic t_abort();
    for (int k = 0; k < 2; k++) begin
      u_host.frame(16'hffff, k == 0 ? 1 : 15);
      wait_ev();
      check({14'h0, got_abort, got_load}, 16'h0002);
      check_state(2'h0, 14'h0123);
    end
  endtask : t_abort

  task automatic t_extra();
    load(16'h0abc);
    u_host.shift_bits(16'hffff, 8);
    repeat (12) @(posedge ref_clk);
    #1;
    check_state(2'h0, 14'h0abc);
  endtask : t_extra

  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    supply_low = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    check_state(2'h0, 14'h0000);
    check({15'h0, output_valid}, 16'h0001);
    t_modes();
    t_wake(1'b0, FAST);
    t_wake(1'b1, SLOW);
    t_abort();
    t_extra();
    u_host.frame_bytes(16'h2345);
    wait_ev();
    check({15'h0, got_load}, 16'h0001);
    check_state(2'h0, 14'h2345);
    finish_test();
  end
endmodule : dsl_top_tb
